// ===== logic/tcsac_regs.svh
// Timing counts and constant codes for the Type-C source attach controller
`ifndef TCSAC_REGS_SVH
`define TCSAC_REGS_SVH
`define TCSAC_CLK_MHZ 125
`define TCSAC_DEBOUNCE_US 400
`define TCSAC_DEBOUNCE_CYC (`TCSAC_DEBOUNCE_US * `TCSAC_CLK_MHZ)
`define TCSAC_VBUS_UP_MS 275
`define TCSAC_VBUS_UP_CYC (`TCSAC_VBUS_UP_MS * 1000 * `TCSAC_CLK_MHZ)
`define TCSAC_BUS_DISCHARGE_SINK_MS 650
`define TCSAC_BUS_DISCHARGE_SINK_CYC (`TCSAC_BUS_DISCHARGE_SINK_MS * 1000 * `TCSAC_CLK_MHZ)
`define TCSAC_PULLUP_UA 330
`define TCSAC_SINK_MA 20
`endif

// ===== logic/tcsac_pkg.sv
// Types for the Type-C source attach controller
package tcsac_pkg;
   typedef enum logic [1:0] {
      ST_UNATTACHED = 2'b00,
      ST_DEBOUNCE = 2'b01,
      ST_CONNECTED = 2'b10,
      ST_DISCHARGE = 2'b11
   } tcsac_state_e;
   // Comparator view of one CC line
   typedef struct packed {
      logic attachDetectVoltage;
      logic cableTerm;
   } tcsac_cc_s;
   // Protocol enables
   typedef struct packed {
      logic pd2;
      logic pd3;
      logic pps;
      logic vdm;
      logic bc12;
      logic legacyFast2;
      logic legacyFast3;
   } tcsac_proto_s;
endpackage : tcsac_pkg

// ===== logic/typec_source_attach_control.sv
// Type-C source attach and detach control with protocol selection
`include "tcsac_regs.svh"

module typec_source_attach_control #(
   parameter int unsigned DEBOUNCE_CYC = `TCSAC_DEBOUNCE_CYC,
   parameter int unsigned VBUS_UP_CYC = `TCSAC_VBUS_UP_CYC,
   parameter int unsigned BUS_DISCHARGE_SINK_CYC = `TCSAC_BUS_DISCHARGE_SINK_CYC,
   parameter bit HAS_DPDM = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // CC comparators, index 0 is CC1
   input tcsac_pkg::tcsac_cc_s cc1,
   input tcsac_pkg::tcsac_cc_s cc2,
   // Mode selection
   input wire logic enhancedMode,
   input wire logic bothMode,
   // Bus level reports
   input wire logic vbusAt5v,
   input wire logic vbusAt0v,
   // Power path
   output logic ccPullupEnable,
   output logic loadSwitchGateDrive,
   output logic busDischargeSink,
   output logic vccCurrentSink,
   // Status
   output logic attached,
   output logic activeCc2,
   output logic pdReady,
   output logic vbusUpTimeout,
   output logic dischargeTimeout,
   output tcsac_pkg::tcsac_proto_s protoEnable
);
   localparam int unsigned CW = 32;
   tcsac_pkg::tcsac_state_e state;
   logic [CW-1:0] timer;
   logic sink1;
   logic sink2;
   logic anySink;
   logic activeSink;
   logic vbusWait;

   // A sink termination wins even with a cable termination on the other line
   assign sink1 = cc1.attachDetectVoltage;
   assign sink2 = cc2.attachDetectVoltage;
   assign anySink = sink1 | sink2;
   assign activeSink = activeCc2 ? sink2 : sink1;

   // Pull-ups stay on so a consumer can always be seen
   always_ff @(posedge clk)
   begin
      if (reset)
         ccPullupEnable <= 1'b0;
      else
         ccPullupEnable <= 1'b1;
   end

   // Attach state machine and shared timer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= tcsac_pkg::ST_UNATTACHED;
         timer <= '0;
      end
      else
      begin
         unique case (state)
            tcsac_pkg::ST_UNATTACHED:
            begin
               timer <= '0;
               if (anySink)
                  state <= tcsac_pkg::ST_DEBOUNCE;
            end
            tcsac_pkg::ST_DEBOUNCE:
            begin
               // Bounce back aborts; avoids closing on a glitch
               if (!anySink)
               begin
                  state <= tcsac_pkg::ST_UNATTACHED;
                  timer <= '0;
               end
               else if (timer >= CW'(DEBOUNCE_CYC - 1))
               begin
                  state <= tcsac_pkg::ST_CONNECTED;
                  timer <= '0;
               end
               else
                  timer <= timer + 1'b1;
            end
            tcsac_pkg::ST_CONNECTED:
            begin
               if (!activeSink)
               begin
                  state <= tcsac_pkg::ST_DISCHARGE;
                  timer <= '0;
               end
               else if (timer < CW'(VBUS_UP_CYC))
                  timer <= timer + 1'b1;
            end
            tcsac_pkg::ST_DISCHARGE:
            begin
               // Leave once bus is at 0 V or the window has run out
               if (vbusAt0v || timer >= CW'(BUS_DISCHARGE_SINK_CYC - 1))
               begin
                  state <= tcsac_pkg::ST_UNATTACHED;
                  timer <= '0;
               end
               else
                  timer <= timer + 1'b1;
            end
         endcase
      end
   end

   // Power path drives, registered from the next state
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         loadSwitchGateDrive <= 1'b0;
         busDischargeSink <= 1'b0;
         vccCurrentSink <= 1'b0;
         attached <= 1'b0;
      end
      else
      begin
         loadSwitchGateDrive <= (state == tcsac_pkg::ST_DEBOUNCE && anySink && timer >= CW'(DEBOUNCE_CYC - 1))
            || (state == tcsac_pkg::ST_CONNECTED && activeSink);
         busDischargeSink <= (state == tcsac_pkg::ST_CONNECTED && !activeSink)
            || (state == tcsac_pkg::ST_DISCHARGE && !(vbusAt0v || timer >= CW'(BUS_DISCHARGE_SINK_CYC - 1)));
         vccCurrentSink <= (state == tcsac_pkg::ST_CONNECTED && !activeSink)
            || (state == tcsac_pkg::ST_DISCHARGE && !(vbusAt0v || timer >= CW'(BUS_DISCHARGE_SINK_CYC - 1)));
         attached <= (state == tcsac_pkg::ST_DEBOUNCE && anySink && timer >= CW'(DEBOUNCE_CYC - 1))
            || (state == tcsac_pkg::ST_CONNECTED && activeSink);
      end
   end

   // Active line captured on entry to debounce; CC1 preferred when both terminated
   always_ff @(posedge clk)
   begin
      if (reset)
         activeCc2 <= 1'b0;
      else if (state == tcsac_pkg::ST_UNATTACHED && anySink)
         activeCc2 <= !sink1 && sink2;
   end

   // Bus rise window supervision
   assign vbusWait = state == tcsac_pkg::ST_CONNECTED && activeSink;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pdReady <= 1'b0;
         vbusUpTimeout <= 1'b0;
      end
      else
      begin
         pdReady <= vbusWait && vbusAt5v && timer < CW'(VBUS_UP_CYC);
         vbusUpTimeout <= vbusWait && !vbusAt5v && timer >= CW'(VBUS_UP_CYC);
      end
   end

   // Sticky until the next attach starts
   always_ff @(posedge clk)
   begin
      if (reset)
         dischargeTimeout <= 1'b0;
      else if (state == tcsac_pkg::ST_DISCHARGE && !vbusAt0v && timer >= CW'(BUS_DISCHARGE_SINK_CYC - 1))
         dischargeTimeout <= 1'b1;
      else if (state == tcsac_pkg::ST_DEBOUNCE)
         dischargeTimeout <= 1'b0;
   end

   // Protocol selection; DP/DM users vanish on the variant without those lines
   always_ff @(posedge clk)
   begin
      if (reset)
         protoEnable <= '0;
      else
      begin
         protoEnable.pd2 <= 1'b1;
         protoEnable.pd3 <= 1'b1;
         protoEnable.pps <= 1'b1;
         protoEnable.vdm <= enhancedMode || bothMode;
         protoEnable.bc12 <= HAS_DPDM;
         protoEnable.legacyFast2 <= HAS_DPDM && !(bothMode && !enhancedMode);
         protoEnable.legacyFast3 <= HAS_DPDM && !(bothMode && !enhancedMode);
      end
   end

   property p_switch_needs_sink;
      @(posedge clk) disable iff (reset)
      $rose(loadSwitchGateDrive) |-> $past(anySink) && $past(state) == tcsac_pkg::ST_DEBOUNCE;
   endproperty
   a_switch_needs_sink: assert property (p_switch_needs_sink) else $error("switch closed without debounce");

   property p_open_on_detach;
      @(posedge clk) disable iff (reset)
      (state == tcsac_pkg::ST_CONNECTED && !activeSink) |=> !loadSwitchGateDrive && busDischargeSink && vccCurrentSink;
   endproperty
   a_open_on_detach: assert property (p_open_on_detach) else $error("detach did not open switch");

   property p_idle_open;
      @(posedge clk) disable iff (reset)
      state == tcsac_pkg::ST_UNATTACHED |-> !loadSwitchGateDrive;
   endproperty
   a_idle_open: assert property (p_idle_open) else $error("switch closed while unattached");

   property p_no_dpdm;
      @(posedge clk) disable iff (reset)
      !HAS_DPDM |=> !protoEnable.bc12 && !protoEnable.legacyFast2 && !protoEnable.legacyFast3;
   endproperty
   a_no_dpdm: assert property (p_no_dpdm) else $error("DP/DM protocol on variant without lines");

   property p_idle_no_sink;
      @(posedge clk) disable iff (reset)
      (state == tcsac_pkg::ST_UNATTACHED && !anySink) |=> state == tcsac_pkg::ST_UNATTACHED && !attached;
   endproperty
   a_idle_no_sink: assert property (p_idle_no_sink) else $error("attach without sink");

   property p_basic_no_legacy;
      @(posedge clk) disable iff (reset)
      (bothMode && !enhancedMode) |=> !protoEnable.legacyFast2 && !protoEnable.legacyFast3;
   endproperty
   a_basic_no_legacy: assert property (p_basic_no_legacy) else $error("legacy protocol in basic mode");
endmodule : typec_source_attach_control

// ===== tb/tcsac_sink_model.sv
// Consumer sink at the cable end, as seen by the CC comparators
module tcsac_sink_model (
   // Termination choice per line, bit 0 is CC1
   input wire logic [1:0] sinkSel,
   input wire logic [1:0] cableSel,
   // Comparator view
   output tcsac_pkg::tcsac_cc_s cc1,
   output tcsac_pkg::tcsac_cc_s cc2
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sink pull-down wins over a cable termination on the same line
   assign cc1.attachDetectVoltage = sinkSel[0];
   assign cc2.attachDetectVoltage = sinkSel[1];
   assign cc1.cableTerm = cableSel[0] & ~sinkSel[0];
   assign cc2.cableTerm = cableSel[1] & ~sinkSel[1];
endmodule : tcsac_sink_model

// ===== tb/typec_source_attach_control_tb.sv
// Self-checking bench for the Type-C source attach controller
module typec_source_attach_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] sinkSel = 2'h0;
   logic [1:0] cableSel = 2'h0;
   logic [1:0] s;
   logic enhancedMode = 1'b0;
   logic bothMode = 1'b0;
   logic vbusAt5v = 1'b0;
   logic vbusAt0v = 1'b0;
   tcsac_pkg::tcsac_cc_s cc1, cc2;
   logic pull, gate, bus_discharge_sink, vccSink, attached, activeCc2, pdReady, upTo, dischTo;
   tcsac_pkg::tcsac_proto_s proto, protoNo;
   int n_errors = 0;
   int checks = 0;
   always #4 clk = ~clk;
   tcsac_sink_model sink (.sinkSel(sinkSel), .cableSel(cableSel), .cc1(cc1), .cc2(cc2));
   typec_source_attach_control #(.DEBOUNCE_CYC(20), .VBUS_UP_CYC(100), .BUS_DISCHARGE_SINK_CYC(100)) dut (
      .clk(clk), .reset(reset), .cc1(cc1), .cc2(cc2), .enhancedMode(enhancedMode), .bothMode(bothMode),
      .vbusAt5v(vbusAt5v), .vbusAt0v(vbusAt0v), .ccPullupEnable(pull), .loadSwitchGateDrive(gate),
      .busDischargeSink(bus_discharge_sink), .vccCurrentSink(vccSink), .attached(attached), .activeCc2(activeCc2),
      .pdReady(pdReady), .vbusUpTimeout(upTo), .dischargeTimeout(dischTo), .protoEnable(proto));
   // Second variant only for protocol selection; its power path is left unobserved
   typec_source_attach_control #(.HAS_DPDM(1'b0)) dutNoDpdm (
      .clk(clk), .reset(reset), .cc1(cc1), .cc2(cc2), .enhancedMode(enhancedMode), .bothMode(bothMode),
      .vbusAt5v(vbusAt5v), .vbusAt0v(vbusAt0v), .ccPullupEnable(), .loadSwitchGateDrive(),
      .busDischargeSink(), .vccCurrentSink(), .attached(), .activeCc2(), .pdReady(), .vbusUpTimeout(),
      .dischargeTimeout(), .protoEnable(protoNo));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Inputs move and outputs are read at the falling edge only
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : cyc
   // Fixed packing of the enables; bc12 follows the DP/DM lines in every mode
   function automatic logic [7:0] got(input tcsac_pkg::tcsac_proto_s p, input logic dp);
      return {1'b0, p.pd2, p.pd3, p.pps, p.vdm, p.legacyFast2, p.legacyFast3, p.bc12};
   endfunction : got
   function automatic logic [7:0] want(input logic en, input logic both, input logic dp);
      return {4'h7, en | both, {2{dp & ~(both & ~en)}}, dp};
   endfunction : want
   task automatic wrap_up;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      #20000;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(24));
      cyc(2);
      reset = 1'b0;
      cyc(1);
      chk("pullup", 8'h1, 8'(pull));
      chk("gate", 8'h0, 8'(gate));
      for (int m = 0; m < 4; m++)
      begin
         {enhancedMode, bothMode} = 2'(m);
         cyc(2);
         chk("proto", want(enhancedMode, bothMode, 1'b1), got(proto, 1'b1));
         chk("protoNoDpdm", want(enhancedMode, bothMode, 1'b0), got(protoNo, 1'b0));
      end
      // Short bounce must not close the switch
      sinkSel = 2'h1;
      cyc(1 + $urandom_range(18));
      sinkSel = 2'h0;
      cyc(25);
      chk("bounceGate", 8'h0, 8'(gate));
      vbusAt5v = 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         s = (k < 3) ? 2'h0 : 2'(k - 2);
         sinkSel = s;
         cableSel = (k < 3) ? 2'(k) : 2'(~s & 2'($urandom));
         cyc(20);
         chk("gateEarly", 8'h0, 8'(gate));
         cyc(1);
         chk("gate", 8'(|s), 8'(gate));
         chk("attached", 8'(|s), 8'(attached));
         if (s != 2'h0)
         begin
            chk("activeCc2", 8'(s == 2'h2), 8'(activeCc2));
            cyc($urandom_range(20, 5));
            chk("pdReady", 8'h1, 8'(pdReady));
            if (s == 2'h3)
            begin
               sinkSel = 2'h1;
               cyc(3);
               chk("inactiveDrop", 8'h1, 8'(gate));
            end
            sinkSel = 2'h0;
            cyc(1);
            chk("detach", 8'h3, {6'h0, bus_discharge_sink, vccSink} | 8'({gate, 2'h0}));
            vbusAt0v = 1'b1;
            cyc(1);
            chk("dischDone", 8'h0, 8'(bus_discharge_sink));
            vbusAt0v = 1'b0;
         end
         sinkSel = 2'h0;
         cableSel = 2'h0;
         cyc(2);
      end
      // Bus never reaches 5 V, then never reaches 0 V
      vbusAt5v = 1'b0;
      sinkSel = 2'h2;
      cyc(121);
      chk("upTimeoutEarly", 8'h0, 8'(upTo));
      cyc(1);
      chk("upTimeout", 8'h1, 8'(upTo));
      chk("pdReadyLow", 8'h0, 8'(pdReady));
      sinkSel = 2'h0;
      cyc(100);
      chk("dischTimeoutEarly", 8'h0, 8'(dischTo));
      cyc(1);
      chk("dischTimeout", 8'h1, 8'(dischTo));
      chk("dischEnd", 8'h0, 8'(bus_discharge_sink));
      wrap_up();
   end
endmodule : typec_source_attach_control_tb
